// ---- design/ulpirs_pkg.sv ----
// Behaviour
// - Leave reset only when internal power-on reset and reset pin are both high.
// - Internal power-on reset pulse is produced once the core supply is stable.
// - With reference clock running at reset release, bus becomes available promptly.
// - Register defaults are reloaded whenever the core supply comes up or cycles.
// - Reset pin low for at least 1 us resets registers and state machines.
// - Core present, reset low, analog absent gives standby without bus activity.
// - Core present, reset high, analog absent allows register access only.
// - Analog, core and reset all high give full USB operation.
// - Analog present but core absent keeps the bus inactive always.
// - After power-up or reset the default operating state is synchronous mode.
// - Operation starts only with supplies stable, reference clock present, reset high.
// - Reset pin may rise asynchronously and is synchronised inside.
// - From reset release until PLL lock, drive idle data and hold direction high.
// - After lock, check stop is low, then drop direction to hand over bus.
// - While stop stays high after lock, direction stays high.
// - Start-up is measured from reference clock start when it starts late.
// - Loss of cable bus voltage does not stop the bus interface.
// - Low power mode keeps line and cable monitoring enabled.
// - Only rising edges of the reference clock are used, no phase alignment.
package ulpirs_pkg;

  // Clock period of ref_clk in picoseconds.
  localparam int CLK_PERIOD_PS = 5000;

  // Counter width shared by all timing counters.
  localparam int CNT_W = 16;

  // Power-on reset stretch after the core supply settles, in nanoseconds.
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYC = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] POR_CYC_C = CNT_W'(POR_CYC);

  // Shortest reset pin low time that is guaranteed to reset, in nanoseconds.
  localparam int MIN_RESET_NS = 1000;
  localparam int MIN_RESET_CYC = (MIN_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] MIN_RESET_CYC_C = CNT_W'(MIN_RESET_CYC);

  // Reference clock declared absent after this long without a rising edge.
  localparam int REF_TIMEOUT_NS = 200;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] REF_TIMEOUT_CYC_C = CNT_W'(REF_TIMEOUT_CYC);

  // Data bus width and the idle pattern driven while the device owns the bus.
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] ULPI_IDLE = 8'h00;

  // Start-up sequencer states.
  typedef enum logic [2:0] {
    ST_OFF       = 3'b000,
    ST_STANDBY   = 3'b001,
    ST_WAIT_CLK  = 3'b010,
    ST_WAIT_LOCK = 3'b011,
    ST_WAIT_STP  = 3'b100,
    ST_RUN       = 3'b101,
    ST_LOW_POWER = 3'b110
  } ulpirs_state_e;

endpackage

// ---- design/ulpirs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulpirs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Two flops; only the second stage is visible to the rest of the block.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // ulpirs_sync
`default_nettype wire

// ---- design/ulpirs_startup.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulpirs_startup #(
  parameter int DATA_W = ulpirs_pkg::DATA_W
) (
  // Clock and asynchronous reset of the sequencer logic.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Supply presence levels.
  input wire logic core_supply_present,
  input wire logic analog_supply_present,
  // Pins driven by the link.
  input wire logic hard_reset_n_pin,
  input wire logic stp,
  // Reference clock pin, observed only for activity.
  input wire logic pll_ref_clock_in,
  // PLL lock indication.
  input wire logic pll_lock,
  // Low power entry request from the register logic.
  input wire logic lp_enter,
  // Bus direction and data driven by the device.
  output logic dir,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Reset outputs to the register file and the other state machines.
  output logic regs_default_load,
  output logic sm_reset_n,
  // Operating mode indications.
  output logic standby,
  output logic reg_access_only,
  output logic usb_line_en,
  output logic ulpi_active,
  output logic sync_mode,
  output logic low_power,
  output logic line_monitor_en,
  output logic ref_clk_ok,
  output logic reset_len_ok
);

  ulpirs_pkg::ulpirs_state_e state_q;
  ulpirs_pkg::ulpirs_state_e state_d;
  logic [1:0] pins_s;
  logic pin_hi;
  logic ref_s;
  logic ref_prev_q;
  logic ref_rise;
  logic [ulpirs_pkg::CNT_W-1:0] ref_gap_q;
  logic ref_ok_q;
  logic [ulpirs_pkg::CNT_W-1:0] por_cnt_q;
  logic por_done_q;
  logic por_done_prev_q;
  logic [ulpirs_pkg::CNT_W-1:0] low_cnt_q;
  logic low_long_q;
  logic release_evt;
  logic owns_bus;

  // Saturating increment shared by every timing counter.
  function automatic logic [ulpirs_pkg::CNT_W-1:0] sat_inc(
    input logic [ulpirs_pkg::CNT_W-1:0] value,
    input logic [ulpirs_pkg::CNT_W-1:0] limit
  );
    sat_inc = (value >= limit) ? limit : value + 1'b1;
  endfunction

  // The reset pin and the reference clock pin both arrive without any phase
  // relation to ref_clk, so both pass through the two-flop synchroniser.
  ulpirs_sync #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in({hard_reset_n_pin, pll_ref_clock_in}),
    .sync_out(pins_s)
  );

  assign pin_hi = pins_s[1];
  assign ref_s = pins_s[0];

  // Only rising edges count; the falling edge and the duty cycle are ignored,
  // which keeps a noisy or asymmetric reference from confusing the detector.
  assign ref_rise = ref_s & ~ref_prev_q;

  // Edge history of the synchronised reference clock.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_prev_q <= 1'b0;
    end
    else
    begin
      ref_prev_q <= ref_s;
    end
  end

  // Activity detector: the reference is present while rising edges keep
  // arriving within the timeout. A late-starting reference is therefore seen
  // only when it starts, and start-up is counted from that moment.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_gap_q <= '0;
      ref_ok_q <= 1'b0;
    end
    else if (ref_rise)
    begin
      ref_gap_q <= '0;
      ref_ok_q <= 1'b1;
    end
    else
    begin
      ref_gap_q <= sat_inc(ref_gap_q, ulpirs_pkg::REF_TIMEOUT_CYC_C);
      if (ref_gap_q >= ulpirs_pkg::REF_TIMEOUT_CYC_C)
      begin
        ref_ok_q <= 1'b0;
      end
    end
  end

  // Power-on reset: the core supply must stay present for the full stretch
  // before the internal reset goes high. A dip restarts the stretch at once.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
    end
    else if (!core_supply_present)
    begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
    end
    else
    begin
      por_cnt_q <= sat_inc(por_cnt_q, ulpirs_pkg::POR_CYC_C);
      if (por_cnt_q >= ulpirs_pkg::POR_CYC_C)
      begin
        por_done_q <= 1'b1;
      end
    end
  end

  // Previous power-on reset level, used to spot the supply coming up.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      por_done_prev_q <= 1'b0;
    end
    else
    begin
      por_done_prev_q <= por_done_q;
    end
  end

  // Reset pin low-time meter. Any low resets the block; this only reports
  // whether the last low lasted long enough to be a guaranteed reset.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_cnt_q <= '0;
      low_long_q <= 1'b0;
    end
    else if (!pin_hi)
    begin
      low_cnt_q <= sat_inc(low_cnt_q, ulpirs_pkg::MIN_RESET_CYC_C);
      if (low_cnt_q >= ulpirs_pkg::MIN_RESET_CYC_C - 1'b1)
      begin
        low_long_q <= 1'b1;
      end
      else
      begin
        low_long_q <= 1'b0;
      end
    end
    else
    begin
      low_cnt_q <= '0;
    end
  end

  // Reset release seen by the sequencer: leaving standby for start-up.
  assign release_evt = (state_q == ulpirs_pkg::ST_STANDBY) && (state_d == ulpirs_pkg::ST_WAIT_CLK);

  // Next-state logic. Core supply loss and reset pin low override every
  // other state, so a reset at any time returns all sequencing to its start.
  always_comb
  begin
    state_d = state_q;
    if (!por_done_q)
    begin
      state_d = ulpirs_pkg::ST_OFF;
    end
    else if (!pin_hi)
    begin
      state_d = ulpirs_pkg::ST_STANDBY;
    end
    else
    begin
      unique case (state_q)
        ulpirs_pkg::ST_OFF:
        begin
          state_d = ulpirs_pkg::ST_STANDBY;
        end
        ulpirs_pkg::ST_STANDBY:
        begin
          state_d = ulpirs_pkg::ST_WAIT_CLK;
        end
        ulpirs_pkg::ST_WAIT_CLK:
        begin
          if (ref_ok_q)
          begin
            state_d = ulpirs_pkg::ST_WAIT_LOCK;
          end
        end
        ulpirs_pkg::ST_WAIT_LOCK:
        begin
          if (!ref_ok_q)
          begin
            state_d = ulpirs_pkg::ST_WAIT_CLK;
          end
          else if (pll_lock)
          begin
            state_d = ulpirs_pkg::ST_WAIT_STP;
          end
        end
        ulpirs_pkg::ST_WAIT_STP:
        begin
          if (!pll_lock)
          begin
            state_d = ulpirs_pkg::ST_WAIT_LOCK;
          end
          else if (!stp)
          begin
            state_d = ulpirs_pkg::ST_RUN;
          end
          else
          begin
            state_d = ulpirs_pkg::ST_WAIT_STP;
          end
        end
        ulpirs_pkg::ST_RUN:
        begin
          // Lock loss after handover does not pull the bus back; the
          // session may drop but the interface keeps running.
          if (lp_enter)
          begin
            state_d = ulpirs_pkg::ST_LOW_POWER;
          end
        end
        ulpirs_pkg::ST_LOW_POWER:
        begin
          // Stop wakes the device; the reference may have been stopped, so
          // the full start-up is repeated.
          if (stp)
          begin
            state_d = ulpirs_pkg::ST_WAIT_CLK;
          end
        end
        default:
        begin
          state_d = ulpirs_pkg::ST_OFF;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ulpirs_pkg::ST_OFF;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // The device owns the bus from reset release until handover, and again in
  // low power, where it keeps driving the idle pattern with direction high.
  assign owns_bus = (state_d == ulpirs_pkg::ST_WAIT_CLK) || (state_d == ulpirs_pkg::ST_WAIT_LOCK) ||
                    (state_d == ulpirs_pkg::ST_WAIT_STP) || (state_d == ulpirs_pkg::ST_LOW_POWER);

  // Bus drivers. Data is released together with direction; the link takes
  // over the idle pattern on the following cycle, so there is no overlap.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dir <= 1'b0;
      data_oe <= 1'b0;
      data_out <= DATA_W'(ulpirs_pkg::ULPI_IDLE);
    end
    else
    begin
      dir <= owns_bus;
      data_oe <= owns_bus;
      data_out <= DATA_W'(ulpirs_pkg::ULPI_IDLE);
    end
  end

  // Register defaults reload on supply rise and on every reset release.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regs_default_load <= 1'b0;
      sm_reset_n <= 1'b0;
    end
    else
    begin
      regs_default_load <= (por_done_q & ~por_done_prev_q) | release_evt;
      sm_reset_n <= por_done_q & pin_hi;
    end
  end

  // Mode indications follow the supply and reset combination. Cable bus
  // voltage plays no part here, so its loss leaves the interface running.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      standby <= 1'b0;
      reg_access_only <= 1'b0;
      usb_line_en <= 1'b0;
      ulpi_active <= 1'b0;
      sync_mode <= 1'b0;
      low_power <= 1'b0;
      line_monitor_en <= 1'b0;
    end
    else
    begin
      standby <= state_d == ulpirs_pkg::ST_STANDBY;
      ulpi_active <= state_d == ulpirs_pkg::ST_RUN;
      sync_mode <= state_d == ulpirs_pkg::ST_RUN;
      reg_access_only <= (state_d == ulpirs_pkg::ST_RUN) && !analog_supply_present;
      usb_line_en <= (state_d == ulpirs_pkg::ST_RUN) && analog_supply_present;
      low_power <= state_d == ulpirs_pkg::ST_LOW_POWER;
      line_monitor_en <= state_d == ulpirs_pkg::ST_LOW_POWER;
    end
  end

  // Status of the pin meters, taken straight from their flops.
  assign ref_clk_ok = ref_ok_q;
  assign reset_len_ok = low_long_q;

endmodule // ulpirs_startup
`default_nettype wire

// ---- bench/ulpirs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulpirs_monitor #(
  parameter int DATA_W = ulpirs_pkg::DATA_W
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Inputs of the sequencer.
  input wire logic core_supply_present,
  input wire logic analog_supply_present,
  input wire logic hard_reset_n_pin,
  input wire logic stp,
  input wire logic pll_lock,
  input wire logic lp_enter,
  // Outputs of the sequencer.
  input wire logic dir,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic regs_default_load,
  input wire logic standby,
  input wire logic reg_access_only,
  input wire logic usb_line_en,
  input wire logic ulpi_active,
  input wire logic sync_mode,
  input wire logic low_power,
  input wire logic line_monitor_en,
  input wire logic ref_clk_ok,
  input wire logic reset_len_ok
);
  logic [7:0] low_cnt_q;
  // Length of the current low phase of the pin; it saturates so a long hold never wraps.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_cnt_q <= 8'h00;
    end
    else if (hard_reset_n_pin)
    begin
      low_cnt_q <= 8'h00;
    end
    else if (low_cnt_q != 8'hff)
    begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Three samples cover the two pin synchroniser stages.
  sequence s_live;
    (core_supply_present && hard_reset_n_pin)[*3];
  endsequence
  sequence s_ready;
    (core_supply_present && hard_reset_n_pin && pll_lock && !stp && !lp_enter && ref_clk_ok)[*8];
  endsequence
  property p_idle_drive;
    data_oe == dir && data_out == ulpirs_pkg::ULPI_IDLE;
  endproperty
  property p_stop_hold;
    s_live ##0 (dir && stp) |=> dir;
  endproperty
  property p_lock_wait;
    s_live ##0 (dir && !pll_lock) |=> dir;
  endproperty
  property p_handover;
    $fell(dir) && ulpi_active |-> $past(pll_lock) && !$past(stp);
  endproperty
  property p_run_mode;
    ulpi_active |-> !dir && sync_mode && usb_line_en == $past(analog_supply_present)
      && reg_access_only == !$past(analog_supply_present);
  endproperty
  property p_core_off;
    (!core_supply_present)[*4] |-> !ulpi_active && !dir && !standby;
  endproperty
  property p_pin_low;
    (core_supply_present && !hard_reset_n_pin)[*5] |-> !dir && !ulpi_active;
  endproperty
  property p_start;
    s_ready |-> !dir || low_power;
  endproperty
  property p_pulse;
    regs_default_load |=> !regs_default_load;
  endproperty
  property p_len;
    $rose(reset_len_ok) |-> low_cnt_q inside {[8'hc5:8'hce]};
  endproperty
  property p_lp;
    low_power |-> line_monitor_en && dir && !ulpi_active;
  endproperty
  a_idle_drive: assert property (p_idle_drive)
    else $error("idle drive wrong");
  a_stop_hold: assert property (p_stop_hold)
    else $error("dir dropped with stop high");
  a_lock_wait: assert property (p_lock_wait)
    else $error("dir dropped without lock");
  a_handover: assert property (p_handover)
    else $error("bad handover");
  a_run_mode: assert property (p_run_mode)
    else $error("run mode flags wrong");
  a_core_off: assert property (p_core_off)
    else $error("active without core");
  a_pin_low: assert property (p_pin_low)
    else $error("active with pin low");
  a_start: assert property (p_start)
    else $error("no start");
  a_pulse: assert property (p_pulse)
    else $error("load pulse too long");
  a_len: assert property (p_len)
    else $error("reset length flag timing");
  a_lp: assert property (p_lp)
    else $error("low power flags wrong");
endmodule // ulpirs_monitor

bind ulpirs_startup ulpirs_monitor #(.DATA_W(DATA_W)) u_mon (.ref_clk, .rst_b, .core_supply_present,
  .analog_supply_present, .hard_reset_n_pin, .stp, .pll_lock, .lp_enter, .dir, .data_out, .data_oe,
  .regs_default_load, .standby, .reg_access_only, .usb_line_en, .ulpi_active, .sync_mode, .low_power,
  .line_monitor_en, .ref_clk_ok, .reset_len_ok);
`default_nettype wire

// ---- bench/ulpirs_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulpirs_link_model (
  // Clock and supply seen by the link.
  input wire logic ref_clk,
  input wire logic core_supply_present,
  // Requests from the bench.
  input wire logic pin_req,
  input wire logic stp_req,
  input wire logic ref_en,
  // Direction from the device.
  input wire logic dir,
  // Pins towards the device.
  output logic hard_reset_n_pin,
  output logic stp,
  output logic pll_ref_clock_in,
  output logic link_idle_oe
);
  logic dir_q;
  // The pin is always driven, and kept low while the core supply is missing.
  assign hard_reset_n_pin = pin_req && core_supply_present;
  // Stop follows the bench one edge late, as the link's own flop would.
  initial stp = 1'b1;
  always @(posedge ref_clk)
  begin
    stp <= stp_req;
    dir_q <= dir;
  end
  // Idle starts one cycle after the device releases the bus.
  assign link_idle_oe = !dir && !dir_q;
  // Reference clock near 26 MHz, unrelated in phase, still while disabled.
  initial pll_ref_clock_in = 1'b0;
  always #19.231 pll_ref_clock_in = ref_en ? !pll_ref_clock_in : 1'b0;
endmodule // ulpirs_link_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, rst_b, core_supply_present, analog_supply_present, pll_lock, lp_enter;
  logic pin_req, stp_req, ref_en, hard_reset_n_pin, stp, pll_ref_clock_in, link_idle_oe;
  logic dir, data_oe, regs_default_load, sm_reset_n, standby, reg_access_only, usb_line_en;
  logic ulpi_active, sync_mode, low_power, line_monitor_en, ref_clk_ok, reset_len_ok;
  logic [ulpirs_pkg::DATA_W-1:0] data_out;
  logic [31:0] seed, r;
  integer n_fail, cmp_count, n_rdl, n;
  wire [7:0] got_v = {dir, ulpi_active, sync_mode, usb_line_en, reg_access_only, standby, low_power,
    line_monitor_en};

  ulpirs_startup dut (.ref_clk, .rst_b, .core_supply_present, .analog_supply_present, .hard_reset_n_pin,
    .stp, .pll_ref_clock_in, .pll_lock, .lp_enter, .dir, .data_out, .data_oe, .regs_default_load,
    .sm_reset_n, .standby, .reg_access_only, .usb_line_en, .ulpi_active, .sync_mode, .low_power,
    .line_monitor_en, .ref_clk_ok, .reset_len_ok);
  ulpirs_link_model link (.ref_clk, .core_supply_present, .pin_req, .stp_req, .ref_en, .dir,
    .hard_reset_n_pin, .stp, .pll_ref_clock_in, .link_idle_oe(link_idle_oe));

  // Clock, and a count of register default reloads.
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = !ref_clk;
  initial n_rdl = 0;
  always @(posedge ref_clk) if (regs_default_load === 1'b1) n_rdl++;

  // Model mode: 0 off, 1 standby, 2 device owns bus, 3 run, 4 low power.
  function automatic logic [7:0] exp_vec(input integer m, input logic a);
    exp_vec = {m == 2 || m == 4, m == 3, m == 3, m == 3 && a, m == 3 && !a, m == 1, m == 4, m == 4};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        n_fail++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Waits a bounded time for the model mode; running out ends the run.
  task automatic settle(input integer m, input integer lim);
    integer i;
    begin
      i = 0;
      do
      begin
        @(posedge ref_clk);
        #1;
        i++;
      end
      while (got_v !== exp_vec(m, analog_supply_present) && i < lim);
      chk(got_v, exp_vec(m, analog_supply_present));
      if (got_v !== exp_vec(m, analog_supply_present))
        summarize();
    end
  endtask

  task automatic hold(input integer m, input integer cyc);
    repeat (cyc)
    begin
      @(posedge ref_clk);
      #1;
      chk(got_v, exp_vec(m, analog_supply_present));
    end
  endtask

  // Main sequence; inputs change by non-blocking assignment on the rising edge.
  initial
  begin
    n_fail = 0;
    cmp_count = 0;
    seed = 32'hac7274f1;
    rst_b = 1'b0;
    core_supply_present = 1'b0;
    analog_supply_present = 1'b1;
    pll_lock = 1'b0;
    lp_enter = 1'b0;
    pin_req = 1'b0;
    stp_req = 1'b1;
    ref_en = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    hold(0, 20);
    @(posedge ref_clk);
    core_supply_present <= 1'b1;
    settle(1, 260);
    // The reload counter samples at the edge after the pulse, so let one edge pass.
    @(posedge ref_clk);
    #1;
    chk(8'(n_rdl), 8'h01);
    chk(8'(reset_len_ok), 8'h01);
    chk(8'(sm_reset_n), 8'h00);
    @(posedge ref_clk);
    r = $random(seed);
    analog_supply_present <= r[0];
    pll_lock <= 1'b1;
    stp_req <= 1'b0;
    pin_req <= 1'b1;
    settle(2, 10);
    chk(data_out, ulpirs_pkg::ULPI_IDLE);
    chk(8'(data_oe), 8'h01);
    hold(2, 30);
    chk(8'(ref_clk_ok), 8'h00);
    chk(8'(link_idle_oe), 8'h00);
    @(posedge ref_clk);
    ref_en <= 1'b1;
    settle(3, 40);
    chk(8'(n_rdl), 8'h02);
    chk(8'(ref_clk_ok), 8'h01);
    chk(8'(sm_reset_n), 8'h01);
    @(posedge ref_clk);
    pin_req <= 1'b0;
    settle(1, 6);
    r = $random(seed);
    n = r[0] ? 250 : 150;
    repeat (n) @(posedge ref_clk);
    #1;
    chk(8'(reset_len_ok), 8'(r[0]));
    @(posedge ref_clk);
    r = $random(seed);
    analog_supply_present <= r[1];
    stp_req <= 1'b1;
    pin_req <= 1'b1;
    settle(2, 10);
    hold(2, 10 + r[7:2]);
    chk(8'(n_rdl), 8'h03);
    @(posedge ref_clk);
    pll_lock <= 1'b0;
    hold(2, 20);
    @(posedge ref_clk);
    pll_lock <= 1'b1;
    stp_req <= 1'b0;
    settle(3, 10);
    @(posedge ref_clk);
    lp_enter <= 1'b1;
    @(posedge ref_clk);
    lp_enter <= 1'b0;
    settle(4, 5);
    hold(4, 10);
    @(posedge ref_clk);
    stp_req <= 1'b1;
    settle(2, 5);
    @(posedge ref_clk);
    stp_req <= 1'b0;
    analog_supply_present <= !analog_supply_present;
    settle(3, 20);
    // Stay in run long enough for the start-up check to see a full ready window.
    hold(3, 10);
    chk(8'(link_idle_oe), 8'h01);
    @(posedge ref_clk);
    pll_lock <= 1'b0;
    hold(3, 10);
    @(posedge ref_clk);
    core_supply_present <= 1'b0;
    settle(0, 6);
    hold(0, 10);
    summarize();
  end
endmodule // testbench
`default_nettype wire
